/* strap_mux_pkg.sv */
// package: constants and carrier types for the strap capture and pin mode mux
package strap_mux_pkg;
    localparam int ACCESS_PORTS        = 8;
    localparam int STRAP_WIDTH         = 16;
    localparam int MODULE_DETECT_BIT   = 9;
    localparam int POWER_SAVE_BIT      = 11;
    localparam int TIMEOUT_RESET_BIT   = 12;
    localparam int CLK_MHZ             = 250;
    localparam int TIMEOUT_SECONDS     = 5;
    // cycles = seconds * MHz * 1e6 (1.25e9, fits 32 bits unsigned)
    localparam longint TIMEOUT_CYCLES_L = longint'(TIMEOUT_SECONDS) * CLK_MHZ * 1000000;
    localparam logic [31:0] TIMEOUT_CYCLES = TIMEOUT_CYCLES_L[31:0];
    localparam logic [1:0] MODE_RMII = 2'h3;
    localparam logic [1:0] MODE_MII  = 2'h1;
    localparam logic [1:0] MODE_GENERAL_PURPOSE_SERIAL_MODE = 2'h0;
    localparam logic [1:0] UPLINK_MII = 2'h3;
    localparam logic [3:0] PULL_NONE4 = 4'h0;

    // per access port receive-side pins seen by the pads
    typedef struct packed {
        logic [3:0] rxd;
        logic       crs_dv;
        logic       col;
        logic       txclk;
        logic       rxclk;
    } port_rx_t;

    // per pin pull control, one bit per receive-side pin
    typedef struct packed {
        logic [3:0] rxd;
        logic       crs_dv;
        logic       col;
        logic       txclk;
        logic       rxclk;
    } port_pull_t;

    // captured straps
    typedef struct packed {
        logic       module_detect;
        logic       power_save;
        logic       timeout_reset;
        logic [7:0] user;
    } strap_t;
endpackage

/* port_strap_and_pin_mode_mux.sv */
// module: reset-time strap capture, access/uplink pin mode mux and timeout reset
`timescale 1ns/1ns

module port_strap_and_pin_mode_mux #(
    parameter logic [31:0] TIMEOUT_COUNT = strap_mux_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic [15:0]                   strap_pins,
    input  wire logic [7:0]                    access_port_tx_enable_in,
    output logic      [7:0]                    access_port_tx_enable_out,
    output logic      [7:0]                    access_port_tx_enable_oe,
    input  wire logic [15:0]                   port_interface_select_ctrl,
    input  wire logic [1:0]                    uplink_interface_select_ctrl,
    input  wire logic [7:0]                    module_present,
    input  wire logic                          uplink_present,
    input  wire strap_mux_pkg::port_rx_t [7:0] port_rx_pins,
    input  wire logic [7:0]                    mac_tx_en,
    input  wire logic [31:0]                   mac_txd,
    output logic      [31:0]                   port_txd_pins,
    output strap_mux_pkg::port_rx_t [7:0]      mac_rx,
    output strap_mux_pkg::port_pull_t [7:0]    pull_up,
    output strap_mux_pkg::port_pull_t [7:0]    pull_down,
    output logic      [7:0]                    clk_out_en,
    output logic                               uplink_mode_ok,
    output logic      [8:0]                    uplink_pull_up,
    output logic      [1:0]                    uplink_pull_down,
    input  wire logic [7:0]                    fsm_busy,
    output logic                               timeout_reset_req,
    output strap_mux_pkg::strap_t              straps,
    output logic                               detect_enable,
    output logic                               power_save_enable,
    output logic      [7:0]                    strap_readback_second
);
    // ==========================================================
    // strap capture
    strap_mux_pkg::strap_t next_straps;
    logic                  out_ready;
    logic                  next_out_ready;

    // sample only while reset is high; frozen afterwards
    always_comb begin
        next_straps = straps;
        next_out_ready = 1'b1;
        if (rst) begin
            next_straps.module_detect = strap_pins[strap_mux_pkg::MODULE_DETECT_BIT];
            next_straps.power_save    = strap_pins[strap_mux_pkg::POWER_SAVE_BIT];
            next_straps.timeout_reset = strap_pins[strap_mux_pkg::TIMEOUT_RESET_BIT];
            next_straps.user          = access_port_tx_enable_in;
            next_out_ready = 1'b0;
        end
    end

    // no reset branch here: the straps themselves are what reset captures
    always_ff @(posedge clk_sys) begin
        straps    <= next_straps;
        out_ready <= next_out_ready;
    end

    assign detect_enable         = straps.module_detect;
    assign power_save_enable     = straps.power_save;
    assign strap_readback_second = straps.user;

    // tx enable only drives once straps are safely held
    always_comb begin
        access_port_tx_enable_oe = out_ready ? 8'hFF : 8'h00;
    end

    // ==========================================================
    // access port mode mux
    function automatic logic [1:0] port_mode(input logic [15:0] f, input int p);
        port_mode = f[2*p +: 2];
    endfunction

    logic [31:0] next_txd;
    logic [7:0]  next_txen;

    genvar g;
    generate
        for (g = 0; g < strap_mux_pkg::ACCESS_PORTS; g++) begin : g_port
            // transmit outputs are registered, mac_rx is not; unused lanes held low
            always_comb begin
                next_txd[4*g +: 4] = 4'h0;
                next_txen[g]       = mac_tx_en[g];
                mac_rx[g]          = '0;
                pull_up[g]         = '0;
                pull_down[g]       = '0;
                clk_out_en[g]      = 1'b0;
                pull_down[g].col   = 1'b1;
                if (detect_enable && !module_present[g]) begin
                    // no module: every input pulled, transmit data and enable still driven, clock output off
                    pull_up[g].rxd    = 4'hF;
                    pull_up[g].crs_dv = 1'b1;
                    pull_up[g].txclk  = 1'b1;
                    pull_up[g].rxclk  = 1'b1;
                    next_txd[4*g +: 4] = mac_txd[4*g +: 4];
                end else begin
                    case (port_mode(port_interface_select_ctrl, g))
                        strap_mux_pkg::MODE_RMII: begin
                            mac_rx[g].rxd[1:0] = port_rx_pins[g].rxd[1:0];
                            mac_rx[g].crs_dv   = port_rx_pins[g].crs_dv;
                            next_txd[4*g +: 2] = mac_txd[4*g +: 2];
                            pull_up[g].rxd[3:2] = 2'h3;
                            pull_up[g].txclk    = 1'b1;
                            pull_up[g].rxclk    = 1'b1;
                        end
                        strap_mux_pkg::MODE_MII: begin
                            mac_rx[g] = port_rx_pins[g];
                            next_txd[4*g +: 4] = mac_txd[4*g +: 4];
                            pull_down[g].col = 1'b0;
                            clk_out_en[g] = 1'b1;
                        end
                        strap_mux_pkg::MODE_GENERAL_PURPOSE_SERIAL_MODE: begin
                            mac_rx[g].rxd[0] = port_rx_pins[g].rxd[0];
                            mac_rx[g].crs_dv = port_rx_pins[g].crs_dv;
                            mac_rx[g].col    = port_rx_pins[g].col;
                            mac_rx[g].txclk  = port_rx_pins[g].txclk;
                            mac_rx[g].rxclk  = port_rx_pins[g].rxclk;
                            next_txd[4*g]    = mac_txd[4*g];
                            pull_up[g].rxd[3:1] = 3'h7;
                            pull_down[g].col = 1'b0;
                            clk_out_en[g] = 1'b1;
                        end
                        default: begin
                            // reserved code: treat as unused, rxd and crs_dv pulled up, col pulled down, tx enable off
                            pull_up[g].rxd = 4'hF;
                            pull_up[g].crs_dv = 1'b1;
                            next_txen[g] = 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // registered transmit pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_txd_pins             <= 32'h0;
            access_port_tx_enable_out <= 8'h00;
        end else begin
            port_txd_pins             <= next_txd;
            access_port_tx_enable_out <= next_txen;
        end
    end

    // ==========================================================
    // uplink: mii only
    // pull order: rxd3..0, rxdv, rxclk, txen, refclk, txclk / crs, col
    always_comb begin
        uplink_mode_ok   = uplink_interface_select_ctrl == strap_mux_pkg::UPLINK_MII;
        uplink_pull_up   = 9'h000;
        uplink_pull_down = 2'h0;
        if (detect_enable && !uplink_present) begin
            uplink_pull_up   = 9'h1FF;
            uplink_pull_down = 2'h3;
        end
    end

    // ==========================================================
    // timeout watchdog
    logic [31:0] busy_cnt;
    logic [31:0] next_busy_cnt;
    logic        next_timeout;

    // counter restarts whenever every machine is idle
    always_comb begin
        next_busy_cnt = 32'h0;
        next_timeout  = 1'b0;
        if (straps.timeout_reset && |fsm_busy) begin
            next_busy_cnt = (busy_cnt == TIMEOUT_COUNT) ? busy_cnt : busy_cnt + 32'h1;
            next_timeout  = busy_cnt == TIMEOUT_COUNT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_cnt          <= 32'h0;
            timeout_reset_req <= 1'b0;
        end else begin
            busy_cnt          <= next_busy_cnt;
            timeout_reset_req <= next_timeout;
        end
    end

    // ==========================================================
    // checks
    property p_strap_hold;
        @(posedge clk_sys) disable iff (rst) !$past(rst) |-> $stable(straps);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset");

    property p_capture;
        @(posedge clk_sys) rst |=> straps.user == $past(access_port_tx_enable_in);
    endproperty
    a_capture: assert property (p_capture) else $error("user strap not captured");

    property p_oe_off;
        @(posedge clk_sys) rst |=> access_port_tx_enable_oe == 8'h00;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("tx enable driven in reset");

    property p_uplink;
        @(posedge clk_sys) disable iff (rst)
            (detect_enable && !uplink_present) |-> uplink_pull_down == 2'h3;
    endproperty
    a_uplink: assert property (p_uplink) else $error("uplink pulldown missing");

    property p_timeout;
        @(posedge clk_sys) disable iff (rst)
            timeout_reset_req |-> $past(straps.timeout_reset) && $past(|fsm_busy);
    endproperty
    a_timeout: assert property (p_timeout) else $error("spurious timeout reset");

    property p_mii_clk;
        @(posedge clk_sys) disable iff (rst)
            (port_interface_select_ctrl[1:0] == strap_mux_pkg::MODE_RMII && module_present[0])
                |-> !clk_out_en[0];
    endproperty
    a_mii_clk: assert property (p_mii_clk) else $error("rmii port drives clock");

    c_timeout: cover property (@(posedge clk_sys) timeout_reset_req);
    c_detect: cover property (@(posedge clk_sys) detect_enable && !module_present[0]);
    c_mii: cover property (@(posedge clk_sys) clk_out_en[0]);
endmodule

/* phy_model.sv */
// model of the external PHYs on the eight access ports
`timescale 1ns/1ns
module phy_model (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic [7:0]               strap_value,
    output logic      [7:0]               access_port_tx_enable_in = 8'h00,
    output strap_mux_pkg::port_rx_t [7:0] port_rx_pins = '0
);
    integer seed = 21500;
    // resistor level on the tx enable pads only under reset; after that the
    // pads invert every cycle so a late strap capture shows up as a wrong value;
    // receive pins wander every cycle, as live PHYs would
    always @(posedge clk_sys) begin
        access_port_tx_enable_in <= rst ? strap_value : ~access_port_tx_enable_in;
        port_rx_pins             <= {$random(seed), $random(seed)};
    end
endmodule

/* port_strap_and_pin_mode_mux_tb.sv */
// self-checking bench for the strap capture and pin mode mux
`timescale 1ns/1ns
module port_strap_and_pin_mode_mux_tb;
    logic                            clk_sys = 1'b0;
    logic                            rst = 1'b1;
    logic [15:0]                     strap_pins = 16'h0000, sp, pctl = 16'hFFFF;
    logic [7:0]                      strap_value = 8'h00, mac_tx_en = 8'h00, present = 8'hFF;
    logic [31:0]                     mac_txd = 32'h0000_0000;
    logic [7:0]                      fsm_busy = 8'h00, txen_in, txen_out, oe, clk_out_en, rdbk;
    logic [1:0]                      up_ctl = 2'h3, up_pd, m;
    logic                            up_present = 1'b1, up_ok, req, det_en, ps_en;
    logic [31:0]                     port_txd_pins;
    logic [8:0]                      up_pu;
    strap_mux_pkg::port_rx_t [7:0]   rx_pins, mac_rx;
    strap_mux_pkg::port_pull_t [7:0] pull_up, pull_down;
    strap_mux_pkg::strap_t           straps;
    integer                          seed = 21500;
    integer                          err_total = 0;
    integer                          checks = 0;
    logic [1:0]                      mode_tab [3] = '{2'h3, 2'h1, 2'h0};

    // ==========================================
    // clock, design and far side
    always #2 clk_sys = ~clk_sys;
    port_strap_and_pin_mode_mux #(.TIMEOUT_COUNT(32'h0000_0010)) uut (
        .clk_sys(clk_sys), .rst(rst), .strap_pins(strap_pins),
        .access_port_tx_enable_in(txen_in), .access_port_tx_enable_out(txen_out),
        .access_port_tx_enable_oe(oe), .port_interface_select_ctrl(pctl),
        .uplink_interface_select_ctrl(up_ctl), .module_present(present),
        .uplink_present(up_present), .port_rx_pins(rx_pins), .mac_tx_en(mac_tx_en),
        .mac_txd(mac_txd), .port_txd_pins(port_txd_pins), .mac_rx(mac_rx),
        .pull_up(pull_up), .pull_down(pull_down), .clk_out_en(clk_out_en),
        .uplink_mode_ok(up_ok), .uplink_pull_up(up_pu), .uplink_pull_down(up_pd),
        .fsm_busy(fsm_busy), .timeout_reset_req(req), .straps(straps),
        .detect_enable(det_en), .power_save_enable(ps_en), .strap_readback_second(rdbk));
    phy_model phy (.clk_sys(clk_sys), .rst(rst), .strap_value(strap_value),
        .access_port_tx_enable_in(txen_in), .port_rx_pins(rx_pins));

    // ==========================================
    // expectations and shared tasks
    // receive pins a mode uses, laid out as {rxd, crs_dv, col, txclk, rxclk}
    function automatic logic [7:0] used_rx(input logic [1:0] md);
        return (md == 2'h3) ? 8'h38 : (md == 2'h1) ? 8'hFF : 8'h1F;
    endfunction
    function automatic logic [3:0] used_tx(input logic [1:0] md);
        return (md == 2'h3) ? 4'h3 : (md == 2'h1) ? 4'hF : 4'h1;
    endfunction
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // strap pins flip right after release, so a late capture is caught
    task automatic do_reset(input logic [15:0] s, input logic [7:0] t);
        @(posedge clk_sys);
        rst         <= 1'b1;
        strap_pins  <= s;
        strap_value <= t;
        repeat (4) @(posedge clk_sys);
        rst         <= 1'b0;
        strap_pins  <= ~s;
        strap_value <= ~t;
        @(negedge clk_sys);
        check("oe_in_reset", oe, 8'h00);
        repeat (2) @(negedge clk_sys);
        check("oe_after", oe, 8'hFF);
        check("detect", det_en, s[9]);
        check("power_save", ps_en, s[11]);
        check("timeout_strap", straps.timeout_reset, s[12]);
        check("readback", rdbk, t);
        check("user", straps.user, t);
    endtask

    // ==========================================
    // main sequence
    initial begin
        sp = 16'($random(seed));
        do_reset(sp, sp[7:0]);
        do_reset(~sp, ~sp[7:0]);
        // random per-port modes with live traffic
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            for (int p = 0; p < 8; p++) pctl[2*p +: 2] <= mode_tab[$unsigned($random(seed)) % 3];
            mac_tx_en <= 8'($random(seed));
            mac_txd   <= $random(seed);
            @(negedge clk_sys);
            for (int p = 0; p < 8; p++) begin
                m = pctl[2*p +: 2];
                check("mac_rx", mac_rx[p], rx_pins[p] & used_rx(m));
                check("pull_up", pull_up[p], ~used_rx(m) & 8'hFB);
                check("pull_down", pull_down[p], {5'h00, m == 2'h3, 2'h0});
                check("clk_out_en", clk_out_en[p], m != 2'h3);
            end
            @(negedge clk_sys);
            for (int p = 0; p < 8; p++) begin
                m = pctl[2*p +: 2];
                check("txd", port_txd_pins[4*p +: 4], mac_txd[4*p +: 4] & used_tx(m));
                check("txen", txen_out[p], mac_tx_en[p]);
            end
        end
        // reserved code keeps transmit enable low
        @(posedge clk_sys);
        pctl      <= 16'hAAAA;
        mac_tx_en <= 8'hFF;
        repeat (2) @(negedge clk_sys);
        check("txen_reserved", txen_out, 8'h00);
        for (int u = 0; u < 4; u++) begin
            @(posedge clk_sys);
            up_ctl <= u[1:0];
            @(negedge clk_sys);
            check("uplink_ok", up_ok, u == 3);
        end
        // detection on, nothing plugged in
        do_reset(16'h1200, 8'h5A);
        @(posedge clk_sys);
        present    <= 8'h00;
        up_present <= 1'b0;
        @(negedge clk_sys);
        for (int p = 0; p < 8; p++) check("absent_pu", pull_up[p], 8'hFB);
        for (int p = 0; p < 8; p++) check("absent_pd", pull_down[p], 8'h04);
        check("up_pu", up_pu, 9'h1FF);
        check("up_pd", up_pd, 2'h3);
        check("absent_rx", mac_rx, 64'h0);
        // empty sockets still see their transmit pins driven, one cycle on
        @(negedge clk_sys);
        check("absent_txen", txen_out, mac_tx_en);
        check("absent_txd", port_txd_pins, mac_txd);
        // an idle cycle restarts the busy count; 16 in sim stands for 5 s
        @(posedge clk_sys);
        fsm_busy <= 8'h10;
        repeat (10) @(negedge clk_sys);
        @(posedge clk_sys);
        fsm_busy <= 8'h00;
        @(posedge clk_sys);
        fsm_busy <= 8'h01;
        repeat (12) @(negedge clk_sys);
        check("timeout_early", req, 1'b0);
        repeat (10) @(negedge clk_sys);
        check("timeout_fire", req, 1'b1);
        do_reset(16'h0000, 8'hFF);
        repeat (30) @(negedge clk_sys);
        check("timeout_off", req, 1'b0);
        check("up_pu_off", up_pu, 9'h000);
        check("up_pd_off", up_pd, 2'h0);
        wrap_up();
    end

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
endmodule
